// [design/power_good_fault_supervisor.sv]
// power-good sequencing and fault supervisor for a buck controller
//
// Design decisions made here: strobed register access and the placing of the registers.
`default_nettype none
module power_good_fault_supervisor (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    // control pins
    input wire logic enable_pin,
    input wire logic deep_sleep_select_n,
    input wire logic deeper_sleep_select,
    input wire logic [5:0] voltage_identification_code,
    // comparator outputs
    input wire supervisor_pkg::sense_t sense,
    // power-good pin, open drain
    input wire logic power_good_in,
    output logic power_good_out,
    output logic power_good_oe,
    // regulator steering
    output supervisor_pkg::setpoint_sel_t setpoint_sel,
    output logic [5:0] captured_code,
    output supervisor_pkg::drive_t drive,
    output supervisor_pkg::faults_t faults,
    output logic power_good_internal
);

    // ==========================================================
    // states
    typedef enum logic [2:0] {
        ST_OFF,
        ST_BOOT,
        ST_WAIT_RELEASE,
        ST_RAMP_DELAY,
        ST_PG_DELAY,
        ST_RUN,
        ST_LATCHED
    } state_t;

    state_t state;
    state_t next_state;

    // ==========================================================
    // input synchronisers
    localparam int SYNC_W = 14;
    logic [SYNC_W-1:0] sync_a;
    logic [SYNC_W-1:0] sync_b;
    logic [SYNC_W-1:0] raw_in;

    assign raw_in = {enable_pin, deep_sleep_select_n, deeper_sleep_select,
                     sense, voltage_identification_code};

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= raw_in;
            sync_b <= sync_a;
        end
    end

    logic en_s;
    logic ds_n_s;
    logic drs_s;
    supervisor_pkg::sense_t sense_s;
    logic [5:0] code_s;

    assign en_s = sync_b[13];
    assign ds_n_s = sync_b[12];
    assign drs_s = sync_b[11];
    assign sense_s = sync_b[10:6];
    assign code_s = sync_b[5:0];

    // shared line level is read only as status
    logic pg_line_a;
    logic pg_line_s;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pg_line_a <= 1'b0;
            pg_line_s <= 1'b0;
        end else begin
            pg_line_a <= power_good_in;
            pg_line_s <= pg_line_a;
        end
    end

    // ==========================================================
    // phase clock enable
    logic [8:0] phase_div;
    logic phase_tick;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            phase_div <= '0;
        end else if (phase_tick) begin
            phase_div <= '0;
        end else begin
            phase_div <= phase_div + 9'h001;
        end
    end

    assign phase_tick = (phase_div == 9'(supervisor_pkg::PHASE_DIV - 1));

    // ==========================================================
    // enable edge and mode decode
    logic en_q;
    logic en_fall;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            en_q <= 1'b0;
        end else begin
            en_q <= en_s;
        end
    end

    assign en_fall = en_q && !en_s;

    supervisor_pkg::setpoint_sel_t mode_sel;

    always_comb begin
        if (ds_n_s) begin
            mode_sel = supervisor_pkg::SEL_CODE;
        end else if (drs_s) begin
            mode_sel = supervisor_pkg::SEL_DEEPER;
        end else begin
            mode_sel = supervisor_pkg::SEL_DEEP;
        end
    end

    // ==========================================================
    // fault latches and counters
    logic ov_latch;
    logic uv_latch;
    logic oc_latch;
    logic [5:0] uv_count;
    logic [5:0] oc_count;
    logic fault_any;
    logic monitor_on;

    assign monitor_on = (state == ST_RUN) || (state == ST_PG_DELAY);

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ov_latch <= 1'b0;
        end else if (sense_s.above_ov && state != ST_OFF) begin
            ov_latch <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            uv_count <= '0;
        end else if (!sense_s.below_uv || !monitor_on) begin
            uv_count <= '0;
        end else if (phase_tick && uv_count <= 6'(supervisor_pkg::UV_LIMIT)) begin
            uv_count <= uv_count + 6'h01;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            uv_latch <= 1'b0;
        end else if (en_fall) begin
            uv_latch <= 1'b0;
        end else if (uv_count > 6'(supervisor_pkg::UV_LIMIT)) begin
            uv_latch <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            oc_count <= '0;
        end else if (!monitor_on) begin
            oc_count <= '0;
        end else if (phase_tick && sense_s.over_current) begin
            if (oc_count < 6'(supervisor_pkg::OC_LIMIT)) begin
                oc_count <= oc_count + 6'h01;
            end
        end else if (phase_tick && oc_count != 6'h00) begin
            oc_count <= oc_count - 6'h01;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            oc_latch <= 1'b0;
        end else if (en_fall) begin
            oc_latch <= 1'b0;
        end else if (oc_count == 6'(supervisor_pkg::OC_LIMIT)) begin
            oc_latch <= 1'b1;
        end
    end

    assign fault_any = ov_latch || uv_latch || oc_latch;

    // ==========================================================
    // sequencing
    logic [10:0] ramp_count;
    logic [11:0] pg_count;

    always_comb begin
        next_state = state;
        case (state)
            ST_OFF: begin
                if (en_s) begin
                    next_state = ST_BOOT;
                end
            end
            ST_BOOT: begin
                next_state = ST_WAIT_RELEASE;
            end
            ST_WAIT_RELEASE: begin
                if (sense_s.pg_current) begin
                    next_state = ST_RAMP_DELAY;
                end
            end
            ST_RAMP_DELAY: begin
                if (ramp_count == 11'(supervisor_pkg::RAMP_DELAY_CYCLES - 1)) begin
                    next_state = ST_PG_DELAY;
                end
            end
            ST_PG_DELAY: begin
                if (phase_tick &&
                    pg_count == 12'(supervisor_pkg::PG_DELAY_PHASES - 1)) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
            end
            ST_LATCHED: begin
            end
            default: begin
                next_state = ST_OFF;
            end
        endcase
        if (!en_s) begin
            next_state = ST_OFF;
        end else if (uv_latch || oc_latch) begin
            next_state = ST_LATCHED;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state <= ST_OFF;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ramp_count <= '0;
        end else if (state != ST_RAMP_DELAY) begin
            ramp_count <= '0;
        end else begin
            ramp_count <= ramp_count + 11'h001;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pg_count <= '0;
        end else if (state != ST_PG_DELAY) begin
            pg_count <= '0;
        end else if (phase_tick) begin
            pg_count <= pg_count + 12'h001;
        end
    end

    // code capture on detected current, then tracking of the code through pg delay and run
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            captured_code <= '0;
        end else if (state == ST_WAIT_RELEASE && sense_s.pg_current) begin
            captured_code <= code_s;
        end else if (state == ST_PG_DELAY || state == ST_RUN) begin
            captured_code <= code_s;
        end
    end

    // ==========================================================
    // transition suppress window
    logic [5:0] last_code;
    supervisor_pkg::setpoint_sel_t last_mode;
    logic [5:0] mask_count;
    logic change_seen;

    assign change_seen = (code_s != last_code) || (mode_sel != last_mode);

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            last_code <= '0;
            last_mode <= supervisor_pkg::SEL_CODE;
        end else begin
            last_code <= code_s;
            last_mode <= mode_sel;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            mask_count <= '0;
        end else if (change_seen) begin
            mask_count <= 6'(supervisor_pkg::MASK_PHASES);
        end else if (phase_tick && mask_count != 6'h00) begin
            mask_count <= mask_count - 6'h01;
        end
    end

    // ==========================================================
    // register port
    logic [31:0] control;
    logic soft_suppress;

    assign soft_suppress = control[supervisor_pkg::CTRL_SUPPRESS_BIT];

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            control <= supervisor_pkg::CONTROL_RESET;
        end else if (reg_write && reg_addr == supervisor_pkg::REG_CONTROL) begin
            control <= {31'h0, reg_wdata[supervisor_pkg::CTRL_SUPPRESS_BIT]};
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= '0;
        end else if (reg_read) begin
            case (reg_addr)
                supervisor_pkg::REG_CONTROL: reg_rdata <= control;
                supervisor_pkg::REG_STATUS: begin
                    reg_rdata <= {21'h0, state, pg_line_s, power_good_internal,
                                  1'b0, mode_sel, ov_latch, uv_latch, oc_latch};
                end
                supervisor_pkg::REG_CODE: reg_rdata <= {26'h0, captured_code};
                supervisor_pkg::REG_PG_COUNT: reg_rdata <= {20'h0, pg_count};
                default: reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    // ==========================================================
    // outputs
    logic next_pg;

    always_comb begin
        next_pg = (state == ST_RUN) && !fault_any
                  && mask_count == 6'h00 && !change_seen
                  && !soft_suppress && !sense_s.below_uv;
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            power_good_internal <= 1'b0;
            power_good_oe <= 1'b1;
        end else begin
            power_good_internal <= next_pg;
            power_good_oe <= !next_pg;
        end
    end

    assign power_good_out = 1'b0;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            setpoint_sel <= supervisor_pkg::SEL_BOOT;
        end else if (state == ST_PG_DELAY || state == ST_RUN) begin
            setpoint_sel <= mode_sel;
        end else begin
            setpoint_sel <= supervisor_pkg::SEL_BOOT;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            drive <= supervisor_pkg::DRIVE_OFF;
        end else if (ov_latch || (sense_s.above_ov && state != ST_OFF)) begin
            if (sense_s.above_release) begin
                drive <= supervisor_pkg::DRIVE_LOW;
            end else begin
                drive <= supervisor_pkg::DRIVE_OFF;
            end
        end else if (state == ST_OFF || state == ST_LATCHED || fault_any) begin
            drive <= supervisor_pkg::DRIVE_OFF;
        end else begin
            drive <= supervisor_pkg::DRIVE_PWM;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            faults <= '0;
        end else begin
            faults <= {ov_latch, uv_latch, oc_latch};
        end
    end

endmodule : power_good_fault_supervisor
`default_nettype wire

// [design/supervisor_pkg.sv]
// constants and types for the power-good and fault supervisor
`default_nettype none
package supervisor_pkg;
    // ==========================================================
    // clock and timing
    localparam int CLOCK_MHZ = 125;
    localparam int PHASE_DIV = 379;
    localparam int PG_DELAY_PHASES = 3072;
    localparam int UV_LIMIT = 32;
    localparam int OC_LIMIT = 32;
    localparam int MASK_PHASES = 32;
    localparam int RAMP_DELAY_US = 10;
    localparam int RAMP_DELAY_CYCLES = RAMP_DELAY_US * CLOCK_MHZ;
    // ==========================================================
    // register map
    localparam logic [3:0] REG_CONTROL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_CODE = 4'h8;
    localparam logic [3:0] REG_PG_COUNT = 4'hc;
    localparam int CTRL_SUPPRESS_BIT = 0;
    localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
    // ==========================================================
    // types
    typedef enum logic [1:0] {
        SEL_BOOT,
        SEL_CODE,
        SEL_DEEP,
        SEL_DEEPER
    } setpoint_sel_t;
    typedef enum logic [1:0] {
        DRIVE_OFF,
        DRIVE_PWM,
        DRIVE_LOW
    } drive_t;
    typedef struct packed {
        logic above_ov;
        logic above_release;
        logic below_uv;
        logic over_current;
        logic pg_current;
    } sense_t;
    typedef struct packed {
        logic ov;
        logic uv;
        logic oc;
    } faults_t;
endpackage : supervisor_pkg
`default_nettype wire

// [testbench/companion_supplies.sv]
// model of the companion supplies on the shared power-good line
`default_nettype none
module companion_supplies (
    // control
    input wire logic hold_low,
    // shared line
    input wire logic device_oe,
    output logic line,
    output logic pg_current
);
    timeunit 1ns;
    timeprecision 1ps;
    // wired-or with pull-up
    assign line = !(hold_low || device_oe);
    assign pg_current = !hold_low && device_oe;
endmodule : companion_supplies
`default_nettype wire

// [testbench/power_good_fault_supervisor_test.sv]
// self-checking bench for the power-good and fault supervisor
`default_nettype none
module power_good_fault_supervisor_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int P = supervisor_pkg::PHASE_DIV;
    typedef struct {logic dsn; logic drs; supervisor_pkg::setpoint_sel_t sel;} row_t;
    logic clock = 0, resetn = 0, reg_write = 0, reg_read = 0, enable_pin = 0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
    logic deep_sleep_select_n = 1, deeper_sleep_select = 0, hold_low = 1;
    logic [5:0] voltage_identification_code = 6'h15, captured_code;
    logic ov_hi = 0, rel_hi = 0, uv_lo = 0, oc_hi = 0, pgc, line;
    logic power_good_out, power_good_oe, power_good_internal;
    supervisor_pkg::sense_t sense;
    supervisor_pkg::setpoint_sel_t setpoint_sel;
    supervisor_pkg::drive_t drive;
    supervisor_pkg::faults_t faults;
    int errors = 0, samples_checked = 0, n;
    row_t rows[3] = '{'{1'b0, 1'b1, supervisor_pkg::SEL_DEEPER},
        '{1'b0, 1'b0, supervisor_pkg::SEL_DEEP}, '{1'b1, 1'b0, supervisor_pkg::SEL_CODE}};
    assign sense = {ov_hi, rel_hi, uv_lo, oc_hi, pgc};
    always #4 clock = ~clock;
    power_good_fault_supervisor u_dut (.clock, .resetn, .reg_addr, .reg_wdata, .reg_write,
        .reg_read, .reg_rdata, .enable_pin, .deep_sleep_select_n, .deeper_sleep_select,
        .voltage_identification_code, .sense, .power_good_in(line), .power_good_out,
        .power_good_oe, .setpoint_sel, .captured_code, .drive, .faults, .power_good_internal);
    companion_supplies u_partner (.hold_low, .device_oe(power_good_oe), .line,
        .pg_current(pgc));
    // ==========================================================
    // tasks
    task automatic tick(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask : tick
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        tick(1);
        reg_write <= 1'b0;
        tick(1);
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        reg_addr <= a;
        reg_read <= 1'b1;
        tick(1);
        reg_read <= 1'b0;
        v = reg_rdata;
        tick(1);
    endtask : rd
    task automatic start_up;
        hold_low <= 1'b1;
        enable_pin <= 1'b1;
        tick(60);
        check("boot hold", supervisor_pkg::SEL_BOOT, setpoint_sel);
        hold_low <= 1'b0;
        tick(8);
        check("captured_code", voltage_identification_code, captured_code);
        for (n = 8; n < 2000 && setpoint_sel === supervisor_pkg::SEL_BOOT; n++) tick(1);
        check("ramp wait", 1, n >= supervisor_pkg::RAMP_DELAY_CYCLES && n < 1265);
        check("pg held", 1, power_good_oe);
    endtask : start_up
    task automatic toggle_enable;
        enable_pin <= 1'b0;
        tick(6);
    endtask : toggle_enable
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : print_verdict
    // ==========================================================
    // watchdog
    initial begin
        repeat (90000) @(posedge clock);
        errors++;
        print_verdict();
    end
    // ==========================================================
    // main sequence
    initial begin
        tick(5);
        resetn <= 1'b1;
        tick(1);
        check("oe in reset", 1, power_good_oe);
        check("drive in reset", supervisor_pkg::DRIVE_OFF, drive);
        rd(supervisor_pkg::REG_CONTROL, d);
        check("control reset", supervisor_pkg::CONTROL_RESET, d);
        wr(supervisor_pkg::REG_CONTROL, 32'hffff_ffff);
        rd(supervisor_pkg::REG_CONTROL, d);
        check("control bits", 32'h1, d);
        wr(supervisor_pkg::REG_CONTROL, 32'h0);
        wr(4'h2, 32'h5a5a_5a5a);
        rd(4'h2, d);
        check("unmapped", 32'h0, d);
        $display("test reset done");
        start_up();
        rd(supervisor_pkg::REG_STATUS, d);
        check("state", 32'h4, {29'h0, d[10:8]});
        for (int i = 0; i < 3; i++) begin
            deep_sleep_select_n <= rows[i].dsn;
            deeper_sleep_select <= rows[i].drs;
            tick(6);
            check("setpoint_sel", rows[i].sel, setpoint_sel);
            check("pg masked", 1, power_good_oe);
        end
        voltage_identification_code <= 6'h2a;
        tick(6);
        check("code tracked", 6'h2a, captured_code);
        check("pg masked", 1, power_good_oe);
        $display("test start-up done");
        oc_hi <= 1'b1;
        tick(10 * P);
        oc_hi <= 1'b0;
        tick(4);
        check("short oc", 0, faults.oc);
        check("drive pwm", supervisor_pkg::DRIVE_PWM, drive);
        tick(12 * P);
        oc_hi <= 1'b1;
        for (n = 0; n < 34 * P && faults.oc !== 1'b1; n++) tick(1);
        check("oc window", 1, n > 30 * P && n < 34 * P);
        check("oc drive off", supervisor_pkg::DRIVE_OFF, drive);
        oc_hi <= 1'b0;
        toggle_enable();
        check("oc released", 0, faults.oc);
        $display("test overcurrent done");
        start_up();
        uv_lo <= 1'b1;
        tick(20 * P);
        uv_lo <= 1'b0;
        tick(2 * P);
        check("uv restart", 0, faults.uv);
        uv_lo <= 1'b1;
        for (n = 0; n < 36 * P && faults.uv !== 1'b1; n++) tick(1);
        check("uv window", 1, n > 32 * P && n < 34 * P);
        uv_lo <= 1'b0;
        toggle_enable();
        check("uv released", 0, faults.uv);
        $display("test undervoltage done");
        start_up();
        rel_hi <= 1'b1;
        ov_hi <= 1'b1;
        for (n = 0; n < 10 && faults.ov !== 1'b1; n++) tick(1);
        check("ov latch", 1, faults.ov);
        check("ov drive low", supervisor_pkg::DRIVE_LOW, drive);
        ov_hi <= 1'b0;
        tick(6);
        check("ov still low", supervisor_pkg::DRIVE_LOW, drive);
        rel_hi <= 1'b0;
        tick(6);
        check("ov drive off", supervisor_pkg::DRIVE_OFF, drive);
        rel_hi <= 1'b1;
        tick(6);
        check("ov cycles low", supervisor_pkg::DRIVE_LOW, drive);
        toggle_enable();
        enable_pin <= 1'b1;
        tick(6);
        check("ov kept", 1, faults.ov);
        resetn <= 1'b0;
        tick(2);
        resetn <= 1'b1;
        tick(1);
        check("ov por clear", 0, faults.ov);
        $display("test overvoltage done");
        print_verdict();
    end
endmodule : power_good_fault_supervisor_test
`default_nettype wire

// [testbench/supervisor_checker_assertions.sv]
// concurrent checks on the supervisor ports
`default_nettype none
module supervisor_checker (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // watched ports
    input wire logic reg_read,
    input wire logic [31:0] reg_rdata,
    input wire logic power_good_out,
    input wire logic power_good_oe,
    input wire logic power_good_internal,
    input wire supervisor_pkg::drive_t drive,
    input wire supervisor_pkg::faults_t faults
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);
    // ==========================================================
    // properties
    a_pg_data_low: assert property (power_good_out == 1'b0)
        else $error("pg data not low");
    a_pg_inverse: assert property (power_good_internal == !power_good_oe)
        else $error("internal pg not inverse of pull");
    a_ov_latch_holds: assert property (faults.ov |=> faults.ov)
        else $error("ov latch cleared");
    a_ov_pulls_low: assert property (faults.ov |-> power_good_oe)
        else $error("ov without pull");
    a_ov_no_pwm: assert property (faults.ov |-> drive != supervisor_pkg::DRIVE_PWM)
        else $error("pwm while ov");
    a_uv_pulls_low: assert property ($rose(faults.uv) |-> power_good_oe [*2])
        else $error("uv without pull");
    a_oc_latched_off: assert property (faults.oc |-> power_good_oe
        && drive == supervisor_pkg::DRIVE_OFF)
        else $error("oc not latched off");
    a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
        else $error("rdata without read");
    c_ov: cover property ($rose(faults.ov));
    c_uv: cover property ($rose(faults.uv));
    c_oc: cover property ($rose(faults.oc));
endmodule : supervisor_checker
bind power_good_fault_supervisor supervisor_checker u_checker (.clock, .resetn, .reg_read,
    .reg_rdata, .power_good_out, .power_good_oe, .power_good_internal, .drive, .faults);
`default_nettype wire
